// ===== logic/rsc_pkg.sv
// Operation
// R1: power-on reset loads program counter with zero
// R2: power-on reset presets port registers to ones
// R3: brownout monitor always active, no enable; code turns it off in power-down
// R4: brownout shorter than qualify time is ignored
// R5: qualified brownout resets and sets cause flag
// R6: four legal threshold codes select level
// R7: illegal code resets after 2~3 ticks, restores
// R8: brownout reset waits 2~3 ticks, keeps code
// R9: threshold code powers up as 01010101
// R10: illegal threshold code sets code fault flag
// R11: cause flags sticky, cleared by writing zero
// R12: brownout monitor off in power-down mode
// R13: cause register bits 6~3 read as zero
// R14: normal watchdog timeout resets, sets timeout flag
// R15: low-power watchdog timeout clears only pc, sp
// R16: timeout and power-down flags follow reset cause
// R17: power-on: interrupts off, timers off, stack, watchdog
// R18: illegal watchdog code resets, sets its flag
// R19: power-down flag cleared by clear-wdt, set by halt
// R20: reset held for stabilisation ticks after power
package rsc_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] RSC_OFS_THR = 8'h00;
    localparam logic [7:0] RSC_OFS_CAUSE = 8'h04;
    localparam logic [7:0] RSC_OFS_WDT = 8'h08;
    localparam logic [7:0] RSC_OFS_STAT = 8'h0c;
    // threshold codes, first one is the power-on value
    localparam logic [7:0] RSC_THR_POR = 8'h55;
    localparam logic [7:0] RSC_THR_L1 = 8'h33;
    localparam logic [7:0] RSC_THR_L2 = 8'h99;
    localparam logic [7:0] RSC_THR_L3 = 8'haa;
    // watchdog control: enable code in 7:3, period in 2:0
    localparam logic [7:0] RSC_WDT_POR = 8'h53;
    localparam logic [4:0] RSC_WE_DIS = 5'h15;
    localparam logic [4:0] RSC_WE_EN = 5'h0a;
    // cause register fields
    localparam int RSC_KEEP_BIT = 7;
    localparam int RSC_BO_BIT = 2;
    localparam int RSC_TC_BIT = 1;
    localparam int RSC_WC_BIT = 0;
    localparam logic [7:0] RSC_CAUSE_POR = 8'h00;
    // status register fields
    localparam int RSC_TO_BIT = 0;
    localparam int RSC_PD_BIT = 1;
    localparam int RSC_BUSY_BIT = 2;
    // timing
    localparam int RSC_CLK_MHZ = 125;
    localparam int RSC_BO_QUAL_NS = 100000;
    localparam int RSC_BO_QUAL_CYC =
        (RSC_BO_QUAL_NS * RSC_CLK_MHZ + 999) / 1000;
    // three slow edges from an unknown phase span two to three periods
    localparam logic [1:0] RSC_DELAY_TICKS = 2'h3;
    localparam int RSC_STAB_TICKS = 16;
    typedef enum logic [1:0] {
        RSC_RUN = 2'b00,
        RSC_WAIT = 2'b01,
        RSC_HOLD = 2'b10
    } rsc_state_t;
endpackage : rsc_pkg

// ===== logic/rsc_reset_source_control.sv
`timescale 1ns/100ps
module rsc_reset_source_control #(
    parameter int BO_QUAL_CYC = rsc_pkg::RSC_BO_QUAL_CYC,
    parameter int STAB_TICKS = rsc_pkg::RSC_STAB_TICKS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic lowspeed_osc_clock,
    input wire logic brownout_detect,
    input wire logic power_down,
    input wire logic low_power_mode,
    input wire logic halt_exec,
    input wire logic clr_wdt_exec,
    input wire logic watchdog_timeout,
    output logic core_reset,
    output logic pc_sp_clear,
    output logic wdt_clear,
    output logic wdt_enable,
    output logic [2:0] wdt_period_sel,
    output logic [1:0] brownout_level_sel,
    output logic brownout_monitor_on,
    output logic idle_sysclk_keep
);
    localparam int BO_W = $clog2(BO_QUAL_CYC + 1);
    localparam int ST_W = $clog2(STAB_TICKS + 1);

    ////////////////////////////////////////////////////////////////////
    // bus slave: zero wait, always okay

    logic wr_pend_reg;
    logic [7:0] addr_reg;
    logic rd_pend_reg;
    logic thr_we;
    logic cause_we;
    logic wdt_we;

    // capture the address phase for the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= hsel && htrans[1] && hwrite;
            rd_pend_reg <= hsel && htrans[1] && !hwrite;
            addr_reg <= {haddr[7:2], 2'b00};
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign thr_we = wr_pend_reg && addr_reg == rsc_pkg::RSC_OFS_THR;
    assign cause_we = wr_pend_reg && addr_reg == rsc_pkg::RSC_OFS_CAUSE;
    assign wdt_we = wr_pend_reg && addr_reg == rsc_pkg::RSC_OFS_WDT;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: bit 1 brownout, bit 0 slow oscillator

    logic [1:0] s1_reg;
    logic [1:0] s2_reg;
    logic [1:0] s3_reg;
    logic [1:0] lvl_reg;
    logic [1:0] agree;
    logic lirc_tick;
    logic bo_low;

    // three stages; a change counts once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_reg <= 2'b00;
            s2_reg <= 2'b00;
            s3_reg <= 2'b00;
            lvl_reg <= 2'b00;
        end else begin
            s1_reg <= {brownout_detect, lowspeed_osc_clock};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= (lvl_reg & ~agree) | (s3_reg & agree);
        end
    end

    assign agree = ~(s2_reg ^ s3_reg);
    assign lirc_tick = agree[0] && s3_reg[0] && !lvl_reg[0];
    assign bo_low = lvl_reg[1];

    ////////////////////////////////////////////////////////////////////
    // brownout qualification

    logic [BO_W-1:0] bo_cnt_reg;
    logic bo_qual;

    // monitor has no enable, only power-down stops it (see R3) (see R12)
    assign brownout_monitor_on = !power_down;

    // the low level must outlast the qualify time (see R4)
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bo_cnt_reg <= '0;
        end else if (!bo_low || power_down) begin
            bo_cnt_reg <= '0;
        end else if (bo_cnt_reg != BO_W'(BO_QUAL_CYC)) begin
            bo_cnt_reg <= bo_cnt_reg + BO_W'(1);
        end
    end

    assign bo_qual = bo_cnt_reg == BO_W'(BO_QUAL_CYC);

    ////////////////////////////////////////////////////////////////////
    // code checks

    logic [7:0] thr_reg;
    logic [7:0] wdt_reg;
    logic thr_bad;
    logic wc_bad;
    logic wdt_full;

    // exactly four legal threshold codes (see R6)
    always_comb begin
        thr_bad = 1'b0;
        unique case (thr_reg)
            rsc_pkg::RSC_THR_POR: brownout_level_sel = 2'd0;
            rsc_pkg::RSC_THR_L1: brownout_level_sel = 2'd1;
            rsc_pkg::RSC_THR_L2: brownout_level_sel = 2'd2;
            rsc_pkg::RSC_THR_L3: brownout_level_sel = 2'd3;
            default: begin
                brownout_level_sel = 2'd0;
                thr_bad = 1'b1;
            end
        endcase
    end

    // only the two documented enable codes are safe (see R18)
    assign wc_bad = wdt_reg[7:3] != rsc_pkg::RSC_WE_DIS &&
        wdt_reg[7:3] != rsc_pkg::RSC_WE_EN;
    assign wdt_enable = wdt_reg[7:3] == rsc_pkg::RSC_WE_EN;
    assign wdt_period_sel = wdt_reg[2:0];
    assign wdt_full = watchdog_timeout && !low_power_mode;

    ////////////////////////////////////////////////////////////////////
    // reset sequencer

    rsc_pkg::rsc_state_t state_reg;
    logic [ST_W-1:0] tick_cnt_reg;
    logic keep_thr_reg;
    logic core_reset_reg;
    logic full_req;
    logic running;

    assign running = state_reg == rsc_pkg::RSC_RUN;
    assign full_req = bo_qual || thr_bad || wc_bad || wdt_full;

    // power-on starts in hold; requests wait three slow ticks,
    // then reset is held for the stabilisation count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= rsc_pkg::RSC_HOLD; // see R20
            tick_cnt_reg <= '0;
            keep_thr_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                rsc_pkg::RSC_RUN: begin
                    tick_cnt_reg <= '0;
                    if (full_req) begin
                        state_reg <= rsc_pkg::RSC_WAIT; // see R14
                        // brownout alone leaves the code alone
                        keep_thr_reg <= !thr_bad && !wc_bad &&
                            !wdt_full; // see R8
                    end
                end
                rsc_pkg::RSC_WAIT: begin
                    if (lirc_tick) begin
                        if (tick_cnt_reg ==
                            ST_W'(rsc_pkg::RSC_DELAY_TICKS - 2'h1)) begin
                            state_reg <= rsc_pkg::RSC_HOLD; // see R7
                            tick_cnt_reg <= '0;
                        end else begin
                            tick_cnt_reg <= tick_cnt_reg + ST_W'(1);
                        end
                    end
                end
                rsc_pkg::RSC_HOLD: begin
                    // a lasting brownout keeps the core in reset
                    if (bo_qual) begin
                        tick_cnt_reg <= '0;
                    end else if (lirc_tick) begin
                        if (tick_cnt_reg == ST_W'(STAB_TICKS - 1)) begin
                            state_reg <= rsc_pkg::RSC_RUN; // see R20
                            tick_cnt_reg <= '0;
                            keep_thr_reg <= 1'b0;
                        end else begin
                            tick_cnt_reg <= tick_cnt_reg + ST_W'(1);
                        end
                    end
                end
                default: begin
                    state_reg <= rsc_pkg::RSC_HOLD;
                    tick_cnt_reg <= '0;
                end
            endcase
        end
    end

    // one reset level zeroes pc, tops the stack, disables interrupts,
    // stops timers and presets ports to input (see R1) (see R2) (see R17)
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_reset_reg <= 1'b1;
        end else begin
            core_reset_reg <= state_reg == rsc_pkg::RSC_HOLD;
        end
    end

    assign core_reset = core_reset_reg;
    assign wdt_clear = core_reset_reg; // counts again on release, see R17

    // low-power timeout only clears pc and stack pointer (see R15)
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_sp_clear <= 1'b0;
        end else begin
            pc_sp_clear <= running && watchdog_timeout && low_power_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control registers

    // threshold code, restored unless a pure brownout caused the reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            thr_reg <= rsc_pkg::RSC_THR_POR; // see R9
        end else if (state_reg == rsc_pkg::RSC_HOLD &&
                     (!keep_thr_reg || thr_bad)) begin
            thr_reg <= rsc_pkg::RSC_THR_POR; // see R7
        end else if (thr_we) begin
            thr_reg <= hwdata[7:0];
        end
    end

    // watchdog control goes back to power-on value on a full reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_reg <= rsc_pkg::RSC_WDT_POR;
        end else if (state_reg == rsc_pkg::RSC_HOLD) begin
            wdt_reg <= rsc_pkg::RSC_WDT_POR;
        end else if (wdt_we) begin
            wdt_reg <= hwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // cause flags: hardware sets, a written zero clears, set wins

    logic [2:0] cause_reg;
    logic [2:0] cause_set;
    logic [2:0] cause_clr;

    assign cause_set = {bo_qual && running, thr_bad, wc_bad}; // see R5
    assign cause_clr = cause_we ? ~hwdata[2:0] : 3'b000;

    // a clear in the same cycle as an event loses (see R10) (see R11)
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cause_reg <= rsc_pkg::RSC_CAUSE_POR[2:0];
            idle_sysclk_keep <= 1'b0;
        end else begin
            cause_reg <= (cause_reg & ~cause_clr) | cause_set; // see R18
            if (cause_we) begin
                idle_sysclk_keep <= hwdata[rsc_pkg::RSC_KEEP_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // timeout and power-down flags

    logic to_reg;
    logic pd_reg;

    // power-on clears both; brownout leaves them (see R16)
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            to_reg <= 1'b0;
            pd_reg <= 1'b0;
        end else begin
            if (running && watchdog_timeout) begin
                to_reg <= 1'b1; // see R14
            end
            if (running && watchdog_timeout && low_power_mode) begin
                pd_reg <= 1'b1; // see R16
            end else if (halt_exec) begin
                pd_reg <= 1'b1; // see R19
            end else if (clr_wdt_exec) begin
                pd_reg <= 1'b0; // see R19
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux, unmapped reads give zero

    // bits 6~3 of the cause word are hard zero (see R13)
    always_comb begin
        hrdata = 32'h0000_0000;
        if (rd_pend_reg) begin
            unique case (addr_reg)
                rsc_pkg::RSC_OFS_THR: hrdata[7:0] = thr_reg;
                rsc_pkg::RSC_OFS_CAUSE:
                    hrdata[7:0] = {idle_sysclk_keep, 4'h0, cause_reg};
                rsc_pkg::RSC_OFS_WDT: hrdata[7:0] = wdt_reg;
                rsc_pkg::RSC_OFS_STAT: begin
                    hrdata[rsc_pkg::RSC_TO_BIT] = to_reg;
                    hrdata[rsc_pkg::RSC_PD_BIT] = pd_reg;
                    hrdata[rsc_pkg::RSC_BUSY_BIT] = !running;
                end
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking rsc_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_short_bo_ignored: assert property ( // see R4
        running && !bo_qual && !thr_bad && !wc_bad && !wdt_full
        |=> state_reg != rsc_pkg::RSC_WAIT)
        else $error("reset started without a cause");

    a_bo_flag_set: assert property ( // see R5
        bo_qual && running |=> cause_reg[2] &&
        state_reg == rsc_pkg::RSC_WAIT)
        else $error("qualified brownout not recorded");

    a_thr_fault_flag: assert property ( // see R10
        thr_bad |=> cause_reg[1])
        else $error("threshold fault flag not set");

    a_wait_slow_ticks: assert property ( // see R7
        state_reg == rsc_pkg::RSC_WAIT && lirc_tick &&
        tick_cnt_reg == ST_W'(rsc_pkg::RSC_DELAY_TICKS - 2'h1)
        |=> state_reg == rsc_pkg::RSC_HOLD)
        else $error("reset not begun on last slow tick");

    a_thr_restored: assert property ( // see R7
        state_reg == rsc_pkg::RSC_HOLD && !keep_thr_reg
        |=> thr_reg == rsc_pkg::RSC_THR_POR)
        else $error("threshold code not restored");

    a_thr_kept: assert property ( // see R8
        state_reg == rsc_pkg::RSC_HOLD && keep_thr_reg && !thr_bad &&
        !thr_we |=> $stable(thr_reg))
        else $error("threshold code lost over brownout reset");

    a_flag_sticky: assert property ( // see R11
        $fell(cause_reg[2]) |-> $past(cause_we) && !$past(hwdata[2]))
        else $error("cause flag cleared without a write");

    a_mon_off_pd: assert property ( // see R12
        power_down |=> bo_cnt_reg == '0 && !bo_qual)
        else $error("brownout monitor ran in power-down");

    a_sleep_wdt: assert property ( // see R15
        running && watchdog_timeout && low_power_mode
        |=> pc_sp_clear && to_reg && pd_reg && !core_reset ##1 running)
        else $error("low-power timeout not partial");

    a_wdt_normal: assert property ( // see R14
        running && wdt_full |=> to_reg && !pc_sp_clear &&
        state_reg == rsc_pkg::RSC_WAIT)
        else $error("normal timeout did not start reset");

    a_wc_reset: assert property ( // see R18
        running && wc_bad |=> cause_reg[0] &&
        state_reg == rsc_pkg::RSC_WAIT)
        else $error("watchdog code fault not handled");

    a_pd_halt: assert property ( // see R19
        halt_exec |=> pd_reg)
        else $error("halt did not set power-down flag");

    c_bo_reset: cover property (
        running && bo_qual ##1 state_reg == rsc_pkg::RSC_WAIT);
    c_thr_fault: cover property (
        thr_bad ##1 state_reg == rsc_pkg::RSC_HOLD);
    c_sleep_wdt: cover property (pc_sp_clear);
    c_release: cover property ($fell(core_reset_reg));

endmodule : rsc_reset_source_control

// ===== tb/test_reset_source_control.sv
`timescale 1ns/100ps
module test_reset_source_control;
    // short counts keep each full reset to about a hundred cycles
    localparam int BO_CYC = 8;
    localparam int STAB = 2;
    typedef struct {
        logic [7:0] ofs;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [7:0] obs;
    } rsc_row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire hready;
    logic hreadyout, hresp, core_reset, pc_sp_clear, wdt_clear;
    logic wdt_enable, brownout_monitor_on, idle_sysclk_keep;
    logic [31:0] hrdata;
    logic [2:0] wdt_period_sel;
    logic [1:0] brownout_level_sel;
    logic lowspeed_osc_clock = 1'b0;
    logic brownout_detect = 1'b0;
    logic power_down = 1'b0;
    logic low_power_mode = 1'b0;
    logic halt_exec = 1'b0;
    logic clr_wdt_exec = 1'b0;
    logic watchdog_timeout = 1'b0;
    logic [3:0] osc_div = 4'h0;
    logic [7:0] obs;
    rsc_row_t rows [9];
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    int psc;

    ////////////////////////////////////////////////////////////////////////
    // single slave, so its ready is the bus ready
    assign hready = hreadyout;
    // packed view of the configuration outputs for the table
    assign obs = {idle_sysclk_keep, wdt_enable, wdt_period_sel,
                  brownout_level_sel, brownout_monitor_on};

    rsc_reset_source_control #(.BO_QUAL_CYC(BO_CYC), .STAB_TICKS(STAB)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .lowspeed_osc_clock(lowspeed_osc_clock),
        .brownout_detect(brownout_detect), .power_down(power_down),
        .low_power_mode(low_power_mode), .halt_exec(halt_exec),
        .clr_wdt_exec(clr_wdt_exec), .watchdog_timeout(watchdog_timeout),
        .core_reset(core_reset), .pc_sp_clear(pc_sp_clear),
        .wdt_clear(wdt_clear), .wdt_enable(wdt_enable),
        .wdt_period_sel(wdt_period_sel),
        .brownout_level_sel(brownout_level_sel),
        .brownout_monitor_on(brownout_monitor_on),
        .idle_sysclk_keep(idle_sysclk_keep)
    );

    ////////////////////////////////////////////////////////////////////////
    always #4 hclk = ~hclk;
    // slow oscillator at one sixteenth of the bus clock, free running
    always @(posedge hclk) begin
        osc_div <= osc_div + 4'h1;
        lowspeed_osc_clock <= osc_div[3];
    end
    // hang guard: the whole run needs well under two thousand cycles
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails = fails + 1;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    // one single word transfer; caller stands just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] ofs,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ofs};
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
        logic [31:0] d;
        bus(1'b1, ofs, {24'h0, data}, d);
    endtask : wr

    task automatic rdc(input logic [7:0] ofs, input logic [7:0] exp);
        logic [31:0] d;
        bus(1'b0, ofs, 32'h0, d);
        chk32(d, {24'h0, exp});
    endtask : rdc

    // bounded wait for the full reset to reach a level; returns cycles
    task automatic wait_core(input logic v, output int cnt);
        cnt = 0;
        while (core_reset !== v && cnt < 400) begin
            @(posedge hclk);
            cnt++;
        end
        chk1(core_reset, v);
    endtask : wait_core

    // the comparator output held high for a number of bus cycles
    task automatic hold_bo(input int len);
        brownout_detect <= 1'b1;
        repeat (len) @(posedge hclk);
        brownout_detect <= 1'b0;
        @(posedge hclk);
    endtask : hold_bo

    task final_report;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{
            '{rsc_pkg::RSC_OFS_THR, 8'h33, 8'h33, 8'h5b},
            '{rsc_pkg::RSC_OFS_THR, 8'h99, 8'h99, 8'h5d},
            '{rsc_pkg::RSC_OFS_THR, 8'haa, 8'haa, 8'h5f},
            '{rsc_pkg::RSC_OFS_THR, 8'h55, 8'h55, 8'h59},
            '{rsc_pkg::RSC_OFS_CAUSE, 8'hff, 8'h80, 8'hd9},
            '{rsc_pkg::RSC_OFS_CAUSE, 8'h00, 8'h00, 8'h59},
            '{rsc_pkg::RSC_OFS_WDT, 8'haa, 8'haa, 8'h11},
            '{rsc_pkg::RSC_OFS_WDT, 8'h53, 8'h53, 8'h59},
            '{8'h10, 8'hff, 8'h00, 8'h59}};
        repeat (5) @(posedge hclk);
        chk1(core_reset, 1'b1);
        chk1(wdt_clear, 1'b1);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(rsc_pkg::RSC_OFS_THR, 8'h55);
        rdc(rsc_pkg::RSC_OFS_STAT, 8'h04);
        wait_core(1'b0, n);
        rdc(rsc_pkg::RSC_OFS_STAT, 8'h00);
        for (int i = 0; i < 9; i++) begin
            wr(rows[i].ofs, rows[i].wdata);
            rdc(rows[i].ofs, rows[i].rdata);
            chk32({24'h0, obs}, {24'h0, rows[i].obs});
        end
        // a dip shorter than the qualify time leaves no trace
        hold_bo(4);
        repeat (20) @(posedge hclk);
        rdc(rsc_pkg::RSC_OFS_CAUSE, 8'h00);
        chk1(core_reset, 1'b0);
        // in power-down the monitor is off and a long dip is ignored
        power_down <= 1'b1;
        @(posedge hclk);
        chk1(brownout_monitor_on, 1'b0);
        hold_bo(30);
        repeat (10) @(posedge hclk);
        rdc(rsc_pkg::RSC_OFS_CAUSE, 8'h00);
        power_down <= 1'b0;
        // qualified dip with a legal code keeps that code
        wr(rsc_pkg::RSC_OFS_THR, 8'h33);
        hold_bo(20);
        rdc(rsc_pkg::RSC_OFS_CAUSE, 8'h04);
        wait_core(1'b1, n);
        wait_core(1'b0, n);
        rdc(rsc_pkg::RSC_OFS_THR, 8'h33);
        rdc(rsc_pkg::RSC_OFS_STAT, 8'h00);
        wr(rsc_pkg::RSC_OFS_CAUSE, 8'h00);
        // illegal code: delayed reset, fault flag, code restored
        // two to three slow periods of 16 cycles, plus sync and flops
        wr(rsc_pkg::RSC_OFS_THR, 8'h12);
        wait_core(1'b1, n);
        chk1(n >= 34 && n <= 54, 1'b1);
        rdc(rsc_pkg::RSC_OFS_CAUSE, 8'h02);
        rdc(rsc_pkg::RSC_OFS_THR, 8'h55);
        wait_core(1'b0, n);
        wr(rsc_pkg::RSC_OFS_CAUSE, 8'h02);
        rdc(rsc_pkg::RSC_OFS_CAUSE, 8'h02);
        wr(rsc_pkg::RSC_OFS_CAUSE, 8'h00);
        rdc(rsc_pkg::RSC_OFS_CAUSE, 8'h00);
        // watchdog enable code that is neither pattern
        wr(rsc_pkg::RSC_OFS_WDT, 8'h03);
        wait_core(1'b1, n);
        chk1(n >= 34 && n <= 54, 1'b1);
        rdc(rsc_pkg::RSC_OFS_CAUSE, 8'h01);
        wait_core(1'b0, n);
        rdc(rsc_pkg::RSC_OFS_WDT, 8'h53);
        // watchdog time-out while running: full reset, timeout only
        watchdog_timeout <= 1'b1;
        @(posedge hclk);
        watchdog_timeout <= 1'b0;
        wait_core(1'b1, n);
        wait_core(1'b0, n);
        rdc(rsc_pkg::RSC_OFS_STAT, 8'h01);
        // time-out in sleep: one pc/sp clear, both flags, no reset
        low_power_mode <= 1'b1;
        watchdog_timeout <= 1'b1;
        @(posedge hclk);
        watchdog_timeout <= 1'b0;
        psc = 0;
        repeat (8) begin
            @(posedge hclk);
            psc += int'(pc_sp_clear === 1'b1);
            chk1(core_reset, 1'b0);
        end
        chk1(psc == 1, 1'b1);
        rdc(rsc_pkg::RSC_OFS_STAT, 8'h03);
        low_power_mode <= 1'b0;
        // power-down flag follows clear-watchdog and halt
        clr_wdt_exec <= 1'b1;
        @(posedge hclk);
        clr_wdt_exec <= 1'b0;
        rdc(rsc_pkg::RSC_OFS_STAT, 8'h01);
        halt_exec <= 1'b1;
        @(posedge hclk);
        halt_exec <= 1'b0;
        rdc(rsc_pkg::RSC_OFS_STAT, 8'h03);
        // second power-on in mid-run clears everything
        wr(rsc_pkg::RSC_OFS_THR, 8'h99);
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        chk1(core_reset, 1'b1);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(rsc_pkg::RSC_OFS_THR, 8'h55);
        rdc(rsc_pkg::RSC_OFS_STAT, 8'h04);
        rdc(rsc_pkg::RSC_OFS_CAUSE, 8'h00);
        rdc(rsc_pkg::RSC_OFS_WDT, 8'h53);
        final_report();
    end
endmodule : test_reset_source_control
